/* lan_far_side.sv */
// receive-side requester and serial transmit clock source
// assumes the bench calls its tasks; clock is still between bursts
`default_nettype none
module lan_far_side (
   input  wire logic        mclk,
   output logic             serialTransmitClock,
   output logic             rxAddrValid,
   output logic [47:0]      rxDestAddr,
   output logic             rxFrameEnd,
   output logic [15:0]      rxFrameBytes
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------
   // request pulses; released data inverted
   // ------------------------------------
   initial begin
      serialTransmitClock = 1'b0;
      rxAddrValid = 1'b0;
      rxDestAddr = '0;
      rxFrameEnd = 1'b0;
      rxFrameBytes = '0;
   end
   task automatic addr_check(input logic [47:0] d);
      @(posedge mclk);
      rxAddrValid <= 1'b1;
      rxDestAddr <= d;
      @(posedge mclk);
      rxAddrValid <= 1'b0;
      rxDestAddr <= ~d;
   endtask
   task automatic frame_end(input logic [15:0] n);
      @(posedge mclk);
      rxFrameEnd <= 1'b1;
      rxFrameBytes <= n;
      @(posedge mclk);
      rxFrameEnd <= 1'b0;
      rxFrameBytes <= ~n;
   endtask
   // phase unrelated to mclk, slow enough for the synchroniser
   task automatic burst(input int n);
      repeat (n) begin
         #43 serialTransmitClock = 1'b1;
         #43 serialTransmitClock = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

/* lan_setup_assertions.sv */
// checker for the set-up command executor ports
// assumes binding to the executor with ce held high
`default_nettype none
module lan_setup_checker (
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        rxAddrValid,
   input wire logic        rxFrameEnd,
   input wire logic        rxAddrChecked,
   input wire logic        rxAddrMatch,
   input wire logic        rxFrameChecked,
   input wire logic        rxFrameBad,
   input wire logic        txBitStrobe,
   input wire logic        lineDisconnect,
   input wire logic        externalLoop
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   // ------------------------------------
   // handshake and qualified results
   // ------------------------------------
   apb_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("no ready after one wait");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than a cycle");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   addr_check_a: assert property (rxAddrValid |=> rxAddrChecked)
      else $error("address check late");
   match_qual_a: assert property (rxAddrMatch |-> rxAddrChecked)
      else $error("match without check");
   frame_check_a: assert property (rxFrameEnd |=> rxFrameChecked)
      else $error("frame check late");
   bad_qual_a: assert property (rxFrameBad |-> rxFrameChecked)
      else $error("bad flag without check");
   loop_excl_a: assert property (!(lineDisconnect && externalLoop))
      else $error("both loops active");
   strobe_pulse_a: assert property (txBitStrobe |=> !txBitStrobe)
      else $error("strobe longer than a cycle");
endmodule
bind lan_setup_command_executor lan_setup_checker lan_setup_checker_i (.mclk, .rstn, .psel,
   .penable, .prdata, .pready, .pslverr, .rxAddrValid, .rxFrameEnd, .rxAddrChecked,
   .rxAddrMatch, .rxFrameChecked, .rxFrameBad, .txBitStrobe, .lineDisconnect, .externalLoop);
`default_nettype wire

/* lan_setup_command_executor.sv */
// lan_setup_command_executor: executes no-op, individual address, configure
// and group address list commands, holds the resulting configuration and
// applies it to address matching, frame length checking and loop clocking.
// assumes an APB3 master on mclk; rx match/length requests come from logic
// on mclk; the serial transmit clock is an asynchronous pin.
`default_nettype none

// Functional notes
// - code 0 only logs its code
// - code 1 loads station address for matching
// - station address is broadcast until loaded
// - code 2 updates first count parameter bytes
// - count clamped 4..12, word mode drops odd
// - byte 2 threshold, byte 3 ready/keep bits
// - byte 4 address length, 7 means 0
// - byte 4 bit 3 header location
// - preamble codes give 2,4,8,16 bytes
// - internal loop wins over external loop
// - byte 5 priorities and backoff method
// - byte 9 carrier, check append, polynomial
// - padding forced off without bitstuffing
// - byte 10 filters and sources
// - frames shorter than minimum are bad
// - documented defaults after reset
// - code 3 clears and rebuilds group filter
// - list count rounded down to whole entries
// - zero list count clears hash table
// - internal loop divides transmit clock by four
module lan_setup_command_executor (
   input  wire logic                             mclk,
   input  wire logic                             rstn,
   input  wire logic                             ce,
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [lan_setup_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                      pwdata,
   output logic      [31:0]                      prdata,
   output logic                                  pready,
   output logic                                  pslverr,
   input  wire logic                             serialTransmitClock,
   input  wire logic                             rxAddrValid,
   input  wire logic [47:0]                      rxDestAddr,
   input  wire logic                             rxFrameEnd,
   input  wire logic [15:0]                      rxFrameBytes,
   output logic                                  rxAddrChecked,
   output logic                                  rxAddrMatch,
   output logic                                  rxFrameChecked,
   output logic                                  rxFrameBad,
   output logic                                  txBitStrobe,
   output logic                                  lineDisconnect,
   output logic                                  externalLoop
);
   import lan_setup_pkg::*;

   // -------------------------------------------------------------------------
   // helper functions
   // -------------------------------------------------------------------------

   // byte mask covering the first len address bytes
   function automatic logic [47:0] lenMask(input logic [2:0] len);
      logic [47:0] m;
      m = 48'h0;
      for (int k = 0; k < IA_BYTES; k++) begin
         if (k < int'(len)) begin
            m[k*8 +: 8] = 8'hff;
         end
      end
      return m;
   endfunction

   // six-bit hash: xor fold of the low six bits of every (masked) byte
   function automatic logic [5:0] addrHash(input logic [47:0] addr);
      logic [5:0] h;
      h = 6'h0;
      for (int k = 0; k < IA_BYTES; k++) begin
         h = h ^ addr[k*8 +: 6];
      end
      return h;
   endfunction

   // -------------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------------
   logic        wordMode;
   logic [7:0]  stage [0:11];
   logic [7:0]  cfg [2:11];
   logic [47:0] ia;
   logic [63:0] hash;
   list_state_t listState;
   logic [13:0] listCount;
   logic [13:0] listRemain;
   logic [2:0]  entryPos;
   logic [47:0] entryBuf;
   logic [3:0]  lastCmd;
   logic        txSync1;
   logic        txSync2;
   logic        txSync3;
   logic [1:0]  divCnt;

   // -------------------------------------------------------------------------
   // APB decode
   // -------------------------------------------------------------------------
   wire reqPhase  = psel & penable & ~pready;
   wire accTaken  = psel & penable & pready;
   wire wrTaken   = accTaken & pwrite;
   wire hitCmd    = (paddr == OFF_COMMAND);
   wire hitList   = (paddr == OFF_LIST_DATA);
   wire isListing = (listState == ST_LISTING);
   wire mapped    = (paddr[1:0] == 2'b00) && (paddr <= OFF_STATUS);
   // a new command while a list is pending, or list data with none pending, is refused
   wire refuse    = ~mapped | (pwrite & hitCmd & isListing) | (pwrite & hitList & ~isListing);
   wire wrOk      = wrTaken & ~pslverr;
   wire cmdWrite  = wrOk & hitCmd;
   wire [3:0] cmdCode = pwdata[3:0];
   wire execIa    = cmdWrite & (cmdCode == CMD_IA);
   wire execCfg   = cmdWrite & (cmdCode == CMD_CFG);
   wire execGroup = cmdWrite & (cmdCode == CMD_GROUP);
   wire listWrite = wrOk & hitList;
   wire [7:0] listByte = pwdata[7:0];

   // -------------------------------------------------------------------------
   // configuration field decode
   // -------------------------------------------------------------------------
   wire [3:0] fifoThreshold       = cfg[2][3:0];
   wire       readySyncSelect     = cfg[3][6];
   wire       keepErroredFrames   = cfg[3][7];
   wire [2:0] addressByteCount    = (cfg[4][2:0] == ADDR_LEN_NONE) ? 3'h0 : cfg[4][2:0];
   wire       headerInBufferSelect = cfg[4][3];
   wire [1:0] preambleSize        = cfg[4][5:4];
   wire       internalLoopEnable  = cfg[4][6];
   wire       externalLoopEnable  = cfg[4][7] & ~cfg[4][6];
   wire [2:0] linearPriority      = cfg[5][2:0];
   wire [2:0] exponentialPriority = cfg[5][6:4];
   wire       backoffMethod       = cfg[5][7];
   wire [7:0] spacingApplied      = (cfg[6] < IFS_MIN) ? IFS_MIN : cfg[6];
   wire [2:0] slotLengthHigh      = cfg[8][2:0];
   wire [10:0] slotRaw            = {slotLengthHigh, cfg[7]};
   wire [11:0] slotApplied        = (slotRaw == 11'h0) ? SLOT_ZERO_VALUE : {1'b0, slotRaw};
   wire [3:0] retryCount          = cfg[8][7:4];
   wire       acceptAllFrames     = cfg[9][0];
   wire       broadcastReject     = cfg[9][1];
   wire       lineCodeSelect      = cfg[9][2];
   wire       sendWithoutCarrier  = cfg[9][3];
   wire       checkAppendDisable  = cfg[9][4];
   wire       shortPolynomial     = cfg[9][5];
   wire       bitstuffFraming     = cfg[9][6];
   wire       padApplied          = cfg[9][7] & bitstuffFraming;
   wire [2:0] carrierFilterWidth  = cfg[10][2:0];
   wire       carrierSourceSelect = cfg[10][3];
   wire [2:0] collisionFilterWidth = cfg[10][6:4];
   wire       collisionSourceSelect = cfg[10][7];
   wire [7:0] shortestFrameBytes  = cfg[11];
   // preamble length includes the start indicator
   wire [4:0] preambleBytes       = PREAMBLE_BASE << preambleSize;
   wire [47:0] addrMask           = lenMask(addressByteCount);

   // -------------------------------------------------------------------------
   // configure byte count
   // -------------------------------------------------------------------------
   wire [7:0] cfgCountRaw = stage[0];
   wire [3:0] cfgClamped  = (cfgCountRaw > {4'h0, CFG_COUNT_MAX}) ? CFG_COUNT_MAX :
                            (cfgCountRaw < {4'h0, CFG_COUNT_MIN}) ? CFG_COUNT_MIN :
                            cfgCountRaw[3:0];
   // in word mode the byte of an odd count would be a lone half word
   wire [3:0] cfgCount    = (wordMode & cfgClamped[0]) ? cfgClamped - 4'h1 : cfgClamped;

   // -------------------------------------------------------------------------
   // APB answer: one wait cycle, data and error registered with pready
   // -------------------------------------------------------------------------
   wire [31:0] readData =
      (paddr == OFF_CONTROL)    ? {31'h0, wordMode} :
      (paddr == OFF_COMMAND)    ? {15'h0, isListing, 12'h0, lastCmd} :
      (paddr == OFF_STAGE0)     ? {stage[3], stage[2], stage[1], stage[0]} :
      (paddr == OFF_STAGE1)     ? {stage[7], stage[6], stage[5], stage[4]} :
      (paddr == OFF_STAGE2)     ? {stage[11], stage[10], stage[9], stage[8]} :
      (paddr == OFF_LIST_COUNT) ? {18'h0, listCount} :
      (paddr == OFF_IA_LO)      ? ia[31:0] :
      (paddr == OFF_IA_HI)      ? {16'h0, ia[47:32]} :
      (paddr == OFF_CFG_A)      ? {cfg[5], cfg[4], cfg[3], cfg[2]} :
      (paddr == OFF_CFG_B)      ? {cfg[9], cfg[8], cfg[7], cfg[6]} :
      (paddr == OFF_CFG_C)      ? {16'h0, cfg[11], cfg[10]} :
      (paddr == OFF_EFFECTIVE)  ? {padApplied, externalLoopEnable, internalLoopEnable, preambleBytes,
                                   1'b0, addressByteCount, slotApplied, spacingApplied} :
      (paddr == OFF_HASH_LO)    ? hash[31:0] :
      (paddr == OFF_HASH_HI)    ? hash[63:32] :
      (paddr == OFF_STATUS)     ? {18'h0, listRemain} :
      32'h0;

   // pready drops after each taken access so back-to-back transfers each wait once
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else if (ce) begin
         pready  <= reqPhase;
         pslverr <= reqPhase & refuse;
         prdata  <= (reqPhase & ~pwrite & mapped) ? readData : 32'h0;
      end
   end

   // -------------------------------------------------------------------------
   // control, command log and staging bytes
   // -------------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         wordMode  <= 1'b0;
         lastCmd   <= 4'h0;
         listCount <= 14'h0;
      end else if (ce) begin
         if (wrOk && paddr == OFF_CONTROL) begin
            wordMode <= pwdata[0];
         end
         if (wrOk && paddr == OFF_LIST_COUNT) begin
            listCount <= pwdata[13:0];
         end
         if (cmdWrite) begin
            lastCmd <= cmdCode;                                 // nop only logs its code
         end
      end
   end

   genvar gi;
   generate
      // staging bytes: three words of four bytes, byte 0 in the low lane
      for (gi = 0; gi < 12; gi++) begin : g_stage
         always_ff @(posedge mclk) begin
            if (!rstn) begin
               stage[gi] <= 8'h0;
            end else if (ce && wrOk && paddr == (OFF_STAGE0 + 8'(4 * (gi / 4)))) begin
               stage[gi] <= pwdata[(gi % 4)*8 +: 8];
            end
         end
      end

      // configuration bytes: byte n is taken from staging byte n-1 when n is within count
      for (gi = 2; gi < 12; gi++) begin : g_cfg
         always_ff @(posedge mclk) begin
            if (!rstn) begin
               cfg[gi] <= CFG_RESET[(gi-2)*8 +: 8];
            end else if (ce && execCfg && (4'(gi) <= cfgCount)) begin
               cfg[gi] <= stage[gi-1];
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------------
   // individual address
   // -------------------------------------------------------------------------
   // the broadcast value stands in until the first load; bit 0 is compared like every other masked bit
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ia <= BROADCAST_ADDR;
      end else if (ce && execIa) begin
         ia <= {stage[5], stage[4], stage[3], stage[2], stage[1], stage[0]};
      end
   end

   // -------------------------------------------------------------------------
   // group address list walker
   // -------------------------------------------------------------------------
   // entries complete only when a full address has arrived, so a trailing
   // partial entry is consumed but never hashed; no divider is needed
   wire [47:0] entryNow   = entryBuf | (48'(listByte) << {entryPos, 3'b000});
   wire        entryDone  = (addressByteCount != 3'h0) && ((entryPos + 3'h1) == addressByteCount);
   wire [5:0]  entryIndex = addrHash(entryNow & addrMask);

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         listState  <= ST_IDLE;
         hash       <= 64'h0;
         listRemain <= 14'h0;
         entryPos   <= 3'h0;
         entryBuf   <= 48'h0;
      end else if (ce) begin
         unique case (listState)
            ST_IDLE: begin
               if (execGroup) begin
                  hash       <= 64'h0;
                  listRemain <= listCount;
                  entryPos   <= 3'h0;
                  entryBuf   <= 48'h0;
                  if (listCount != 14'h0) begin
                     listState <= ST_LISTING;
                  end
               end
            end
            ST_LISTING: begin
               if (listWrite) begin
                  listRemain <= listRemain - 14'h1;
                  if (entryDone) begin
                     hash[entryIndex] <= 1'b1;                  // host supplies lsb 1
                     entryPos         <= 3'h0;
                     entryBuf         <= 48'h0;
                  end else begin
                     entryPos <= entryPos + 3'h1;
                     entryBuf <= entryNow;
                  end
                  if (listRemain == 14'h1) begin
                     listState <= ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // received address filter
   // -------------------------------------------------------------------------
   wire [47:0] destMasked = rxDestAddr & addrMask;
   wire        iaHit      = (destMasked == (ia & addrMask));
   wire        bcastHit   = (destMasked == addrMask);
   wire        groupHit   = rxDestAddr[0] & hash[addrHash(destMasked)] & ~bcastHit;
   // accept-all overrides broadcast reject
   wire        destOk     = acceptAllFrames | iaHit | (bcastHit & ~broadcastReject) | groupHit;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rxAddrChecked  <= 1'b0;
         rxAddrMatch    <= 1'b0;
         rxFrameChecked <= 1'b0;
         rxFrameBad     <= 1'b0;
      end else if (ce) begin
         rxAddrChecked  <= rxAddrValid;
         rxAddrMatch    <= rxAddrValid & destOk;
         rxFrameChecked <= rxFrameEnd;
         rxFrameBad     <= rxFrameEnd & (rxFrameBytes < {8'h0, shortestFrameBytes});
      end
   end

   // -------------------------------------------------------------------------
   // serial transmit clock and loop control
   // -------------------------------------------------------------------------
   // the pin is synchronised twice; the third stage only feeds the edge detect
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         txSync1 <= 1'b0;
         txSync2 <= 1'b0;
         txSync3 <= 1'b0;
      end else if (ce) begin
         txSync1 <= serialTransmitClock;
         txSync2 <= txSync1;
         txSync3 <= txSync2;
      end
   end

   wire txRise = txSync2 & ~txSync3;

   // the bit strobe runs at a quarter of the clock in internal loop; the
   // spacing and slot figures are not scaled by it
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         divCnt         <= 2'h0;
         txBitStrobe    <= 1'b0;
         lineDisconnect <= 1'b0;
         externalLoop   <= 1'b0;
      end else if (ce) begin
         if (txRise) begin
            divCnt <= divCnt + 2'h1;
         end
         txBitStrobe    <= txRise & (~internalLoopEnable | (divCnt == LOOP_DIV_LAST));
         lineDisconnect <= internalLoopEnable;
         externalLoop   <= externalLoopEnable;
      end
   end

endmodule
`default_nettype wire

/* lan_setup_command_executor_tb_top.sv */
// self-checking bench for the set-up command executor
// assumes the far side model and the bound checker
`default_nettype none
module lan_setup_command_executor_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import lan_setup_pkg::*;
   logic mclk, rstn, ce, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [47:0] rxDestAddr;
   logic [15:0] rxFrameBytes;
   logic serialTransmitClock, rxAddrValid, rxFrameEnd, rxAddrChecked, rxAddrMatch;
   logic rxFrameChecked, rxFrameBad, txBitStrobe, lineDisconnect, externalLoop;
   int errors, tests_run, cyc, strobes;
   logic [7:0] grp [6] = '{8'h01, 8'h00, 8'h5e, 8'h00, 8'h00, 8'h01};
   lan_setup_command_executor lan_setup_command_executor_i (.mclk, .rstn, .ce, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .serialTransmitClock,
      .rxAddrValid, .rxDestAddr, .rxFrameEnd, .rxFrameBytes, .rxAddrChecked, .rxAddrMatch,
      .rxFrameChecked, .rxFrameBad, .txBitStrobe, .lineDisconnect, .externalLoop);
   lan_far_side lan_far_side_i (.mclk, .serialTransmitClock, .rxAddrValid, .rxDestAddr,
      .rxFrameEnd, .rxFrameBytes);
   // ------------------------------------
   // clock, watchdog and helpers
   // ------------------------------------
   always #5 mclk = ~mclk;
   // the ceiling is far above the under a thousand cycles the run needs
   always @(posedge mclk) begin
      cyc++;
      if (txBitStrobe === 1'b1) strobes++;
      if (cyc == 20000) begin
         errors++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // request held until ready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, rd, e);
   endtask
   task automatic mchk(input logic [47:0] d, input logic e);
      lan_far_side_i.addr_check(d);
      #1 chk("match", {31'h0, rxAddrMatch}, {31'h0, e});
      chk("checked", {31'h0, rxAddrChecked}, 32'h1);
   endtask
   task automatic fchk(input logic [15:0] n, input logic e);
      lan_far_side_i.frame_end(n);
      #1 chk("bad", {31'h0, rxFrameBad}, {31'h0, e});
      chk("fchecked", {31'h0, rxFrameChecked}, 32'h1);
   endtask
   task automatic tx_burst(input int e);
      strobes = 0;
      lan_far_side_i.burst(40);
      repeat (8) @(posedge mclk);
      chk("strobes", strobes, e);
   endtask
   initial begin
      mclk = 0; rstn = 0; ce = 1; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      rdc("cfga", OFF_CFG_A, 32'h00060008);
      rdc("cfgb", OFF_CFG_B, 32'h00f20060);
      rdc("cfgc", OFF_CFG_C, 32'h00004000);
      rdc("eff", OFF_EFFECTIVE, 32'h02620060);
      rdc("ialo", OFF_IA_LO, 32'hffffffff);
      rdc("iahi", OFF_IA_HI, 32'h0000ffff);
      wr(8'h40, 32'h0);
      chk("unmapped", {31'h0, er}, 32'h1);
      wr(OFF_STAGE0, 32'h44332211);
      wr(OFF_STAGE1, 32'h00006655);
      wr(OFF_COMMAND, 32'h1);
      rdc("ialo", OFF_IA_LO, 32'h44332211);
      rdc("iahi", OFF_IA_HI, 32'h00006655);
      mchk(48'h665544332211, 1'b1);
      mchk(48'h665544332200, 1'b0);
      mchk(48'hffffffffffff, 1'b1);
      wr(OFF_COMMAND, 32'h0);
      rdc("ialo", OFF_IA_LO, 32'h44332211);
      // count 2 acts as 4; staged byte 4 must stay out
      wr(OFF_STAGE0, 32'hf7400502);
      wr(OFF_STAGE1, 32'h00001077);
      wr(OFF_COMMAND, 32'h2);
      rdc("cfga", OFF_CFG_A, 32'h00f74005);
      rdc("cfgb", OFF_CFG_B, 32'h00f20060);
      rdc("eff", OFF_EFFECTIVE, 32'h30020060);
      chk("loop", {30'h0, lineDisconnect, externalLoop}, 32'h2);
      tx_burst(10);
      // word mode: count 11 drops byte 11
      wr(OFF_CONTROL, 32'h1);
      wr(OFF_STAGE0, 32'h8600080b);
      wr(OFF_STAGE2, 32'h00100082);
      wr(OFF_COMMAND, 32'h2);
      rdc("cfga", OFF_CFG_A, 32'h77860008);
      rdc("cfgb", OFF_CFG_B, 32'h82000010);
      rdc("cfgc", OFF_CFG_C, 32'h00004000);
      rdc("eff", OFF_EFFECTIVE, 32'h42680020);
      chk("loop", {30'h0, lineDisconnect, externalLoop}, 32'h1);
      tx_burst(40);
      fchk(16'd63, 1'b1);
      fchk(16'd64, 1'b0);
      mchk(48'hffffffffffff, 1'b0);
      wr(OFF_LIST_COUNT, 32'h7);
      wr(OFF_COMMAND, 32'h3);
      rdc("cmd", OFF_COMMAND, 32'h00010003);
      foreach (grp[i]) wr(OFF_LIST_DATA, {24'h0, grp[i]});
      rdc("left", OFF_STATUS, 32'h1);
      wr(OFF_LIST_DATA, 32'h0);
      rdc("hashlo", OFF_HASH_LO, 32'h40000000);
      mchk(48'h0100005e0001, 1'b1);
      wr(OFF_LIST_COUNT, 32'h0);
      wr(OFF_COMMAND, 32'h3);
      rdc("hashlo", OFF_HASH_LO, 32'h0);
      mchk(48'h0100005e0001, 1'b0);
      wr(OFF_LIST_DATA, 32'h0);
      chk("refused", {31'h0, er}, 32'h1);
      finish_test();
   end
endmodule
`default_nettype wire

/* lan_setup_pkg.sv */
// lan_setup_pkg: register map, command codes, configuration byte layout and
// reset values for the set-up command executor.
// assumes a 32-bit APB master with byte addresses; each register is one word.
`default_nettype none
package lan_setup_pkg;

   // ----------------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------------
   localparam int          ADDR_W         = 8;
   localparam logic [7:0] OFF_CONTROL    = 8'h00;
   localparam logic [7:0] OFF_COMMAND    = 8'h04;
   localparam logic [7:0] OFF_STAGE0     = 8'h08;
   localparam logic [7:0] OFF_STAGE1     = 8'h0c;
   localparam logic [7:0] OFF_STAGE2     = 8'h10;
   localparam logic [7:0] OFF_LIST_COUNT = 8'h14;
   localparam logic [7:0] OFF_LIST_DATA  = 8'h18;
   localparam logic [7:0] OFF_IA_LO      = 8'h1c;
   localparam logic [7:0] OFF_IA_HI      = 8'h20;
   localparam logic [7:0] OFF_CFG_A      = 8'h24;
   localparam logic [7:0] OFF_CFG_B      = 8'h28;
   localparam logic [7:0] OFF_CFG_C      = 8'h2c;
   localparam logic [7:0] OFF_EFFECTIVE  = 8'h30;
   localparam logic [7:0] OFF_HASH_LO    = 8'h34;
   localparam logic [7:0] OFF_HASH_HI    = 8'h38;
   localparam logic [7:0] OFF_STATUS     = 8'h3c;

   // ----------------------------------------------------------------------
   // command codes and list walker states
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      CMD_NOP   = 4'h0,
      CMD_IA    = 4'h1,
      CMD_CFG   = 4'h2,
      CMD_GROUP = 4'h3
   } cmd_t;

   typedef enum logic {
      ST_IDLE    = 1'b0,
      ST_LISTING = 1'b1
   } list_state_t;

   // ----------------------------------------------------------------------
   // configure limits and field values
   // ----------------------------------------------------------------------
   localparam logic [3:0]  CFG_COUNT_MIN   = 4'h4;
   localparam logic [3:0]  CFG_COUNT_MAX   = 4'hc;
   localparam logic [2:0]  ADDR_LEN_NONE   = 3'h7;
   localparam logic [7:0]  IFS_MIN         = 8'h20;
   localparam logic [11:0] SLOT_ZERO_VALUE = 12'h800;
   localparam logic [4:0]  PREAMBLE_BASE   = 5'h02;
   localparam logic [1:0]  LOOP_DIV_LAST   = 2'h3;
   localparam logic [47:0] BROADCAST_ADDR  = 48'hffff_ffff_ffff;
   localparam int          IA_BYTES        = 6;

   // reset image of configuration bytes 2..11, byte 2 in the low bits
   localparam logic [79:0] CFG_RESET = {
      8'h40,   // byte 11: shortest frame 64
      8'h00,   // byte 10: filters and sources
      8'h00,   // byte 9: framing and coding
      8'hf2,   // byte 8: 15 retries, slot high 2 (512)
      8'h00,   // byte 7: slot low
      8'h60,   // byte 6: spacing 96
      8'h00,   // byte 5: priorities
      8'h06,   // byte 4: address length 6, preamble code 00
      8'h00,   // byte 3
      8'h08    // byte 2: fifo threshold 8
   };

endpackage
`default_nettype wire
